// ==== hdl/pis_pkg.sv ====
package pis_pkg;

   // ------------------------------------------------------------
   // register indices (byte address is four times the index)
   // ------------------------------------------------------------
   localparam int IDX_GIE = 'h20;
   localparam int IDX_EP_EN = 'h21;
   localparam int IDX_VECTOR = 'h23;
   localparam int IDX_DAC_EN = 'h30;
   localparam int IDX_DAC_POL = 'h31;
   localparam int IDX_GPIO_EN = 'h32;
   localparam int IDX_GPIO_POL = 'h33;
   localparam int IDX_CONFIG = 'h34;
   localparam int IDX_PENDING = 'h35;
   localparam int IDX_SERIAL_SC = 'h36;

   localparam int ADDR_W = 12;
   localparam logic [ADDR_W-1:0] ADDR_GIE = ADDR_W'(IDX_GIE * 4);
   localparam logic [ADDR_W-1:0] ADDR_EP_EN = ADDR_W'(IDX_EP_EN * 4);
   localparam logic [ADDR_W-1:0] ADDR_VECTOR = ADDR_W'(IDX_VECTOR * 4);
   localparam logic [ADDR_W-1:0] ADDR_DAC_EN = ADDR_W'(IDX_DAC_EN * 4);
   localparam logic [ADDR_W-1:0] ADDR_DAC_POL = ADDR_W'(IDX_DAC_POL * 4);
   localparam logic [ADDR_W-1:0] ADDR_GPIO_EN = ADDR_W'(IDX_GPIO_EN * 4);
   localparam logic [ADDR_W-1:0] ADDR_GPIO_POL = ADDR_W'(IDX_GPIO_POL * 4);
   localparam logic [ADDR_W-1:0] ADDR_CONFIG = ADDR_W'(IDX_CONFIG * 4);
   localparam logic [ADDR_W-1:0] ADDR_PENDING = ADDR_W'(IDX_PENDING * 4);
   localparam logic [ADDR_W-1:0] ADDR_SERIAL_SC = ADDR_W'(IDX_SERIAL_SC * 4);

   // ------------------------------------------------------------
   // sizes and field positions
   // ------------------------------------------------------------
   localparam int NUM_EP = 5;
   localparam int NUM_DAC = 8;
   localparam int NUM_PORT = 4;
   localparam int NUM_GPIO = 32;
   localparam int NUM_SRC = 12;
   localparam int GIE_BUS_RESET = 0;
   localparam int GIE_T128 = 1;
   localparam int GIE_T1024 = 2;
   localparam int GIE_DAC = 4;
   localparam int GIE_GPIO = 5;
   localparam int GIE_SERIAL = 6;
   // pending bit k is vector k+1
   localparam int SRC_BUS_RESET = 0;
   localparam int SRC_T128 = 1;
   localparam int SRC_T1024 = 2;
   localparam int SRC_EP0 = 3;
   localparam int SRC_DAC = 9;
   localparam int SRC_GPIO = 10;
   localparam int SRC_SERIAL = 11;
   localparam int CFG_PAR_EN = 0;
   // serial status/control fields
   localparam int SC_PROCEED = 0;
   localparam int SC_MASTER = 1;
   localparam int SC_XMIT = 2;
   localparam int SC_ACK = 3;
   localparam int SC_ADDR = 4;
   localparam int SC_STOP = 5;
   localparam int SC_ARBL = 6;
   localparam int SC_ENABLE = 7;
   localparam logic [7:0] RST_BYTE = 8'h00;
   localparam logic [31:0] RST_WORD = 32'h0000_0000;

   // ------------------------------------------------------------
   // carriers
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NUM_EP-1:0] done;
      logic [NUM_EP-1:0] is_in;
      logic [NUM_EP-1:0] acked;
   } pis_ep_ev_type;

   typedef struct packed {
      logic srx_byte;
      logic first_byte;
      logic srx_stop;
      logic stx_byte;
      logic master_ack;
      logic mtx_byte;
      logic mrx_byte;
      logic arb_lost;
      logic bus_stop;
   } pis_ser_ev_type;

   typedef enum logic [1:0] {CTX_NONE, CTX_MTX, CTX_MRX} pis_mctx_type;

endpackage : pis_pkg

// ==== hdl/pis_irq_ctrl.sv ====
// Added by the designer: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps

// ------------------------------------------------------------
// edge trigger with lockout, shared by dac and gpio pins
// ------------------------------------------------------------
module pis_edge_lock #(parameter int W = 8) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // pins and settings
   input wire logic [W-1:0] pin,
   input wire logic [W-1:0] en,
   input wire logic [W-1:0] pol,
   input wire logic block,
   // result
   output logic fire,
   output logic locked
);
   logic [W-1:0] active;
   logic [W-1:0] prev_reg;
   logic [W-1:0] edges;
   logic lock_vld_reg;
   logic [$clog2(W)-1:0] lock_idx_reg;
   logic [$clog2(W)-1:0] first_idx;
   logic release_now;

   assign active = ~(pin ^ pol);
   assign edges = active & ~prev_reg & en;
   assign release_now = ~active[lock_idx_reg] | ~en[lock_idx_reg];
   assign fire = ~lock_vld_reg & (|edges) & ~block; // [R4] [R8]
   assign locked = lock_vld_reg;

   always_comb begin
      first_idx = '0;
      for (int i = W - 1; i >= 0; i--) begin
         if (edges[i]) begin
            first_idx = ($clog2(W))'(i);
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prev_reg <= '0;
      end else begin
         prev_reg <= active;
      end
   end

   // one pin holds the lock until it goes inactive or loses its enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lock_vld_reg <= 1'b0;
         lock_idx_reg <= '0;
      end else if (lock_vld_reg) begin
         if (release_now) begin
            lock_vld_reg <= 1'b0; // [R6] [R10]
         end
      end else if (fire) begin
         lock_vld_reg <= 1'b1;
         lock_idx_reg <= first_idx;
      end
   end

   property p_lockout;
      @(posedge pclk) disable iff (!presetn)
      lock_vld_reg && !release_now |=> !fire;
   endproperty
   a_lockout: assert property (p_lockout) else $error("pin fired during lockout"); // [R6]

endmodule : pis_edge_lock

`timescale 1ns/1ps

// Overview of operation
// R1: five endpoint sources, each raised by its own endpoint traffic.
// R2: endpoint source raised on final handshake: host ack in, device ack out.
// R3: in transaction without host ack raises nothing.
// R4: dac pin fires on enabled edge, rising or falling per polarity bit.
// R5: all dac pins share one vector, no priority between pins.
// R6: after one dac pin fires, others blocked until it idles or disables.
// R7: dac enables survive interrupt acknowledge.
// R8: gpio pin fires only when enabled, polarity chosen per port.
// R9: all gpio pins share one vector, no priority between pins.
// R10: after one gpio pin fires, others blocked until it idles or disables.
// R11: gpio enables survive interrupt acknowledge.
// R12: parallel host assist owns gpio vector, blocks every gpio pin.
// R13: parallel host assist interrupt gated only by global enable bit 5.
// R14: gpio enables still steer cmos output mode of pins.
// R15: slave receive interrupts per byte, address flag on first byte.
// R16: slave stop sets stop flag and interrupts, unless after a nacked byte.
// R17: slave transmit interrupts per byte, ack bit reports master ack.
// R18: master transmit interrupts per byte; clearing master select sends stop.
// R19: master receive interrupts per byte; master clear plus proceed sends stop.
// R20: arbitration loss clears master, sets flag, interrupts at next stop.
// R21: proceed cleared before conditions one to four; firmware sets it again.
// R22: after master interrupt firmware writes status once setting proceed.
// R23: each source latches pending until serviced or reset, gated by enable.
// R24: lowest pending vector number wins.
module pis_irq_ctrl (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [pis_pkg::ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // event sources on pclk
   input wire logic bus_reset_ev,
   input wire logic t128_ev,
   input wire logic t1024_ev,
   input wire pis_pkg::pis_ep_ev_type ep_ev,
   input wire logic par_ev,
   input wire pis_pkg::pis_ser_ev_type ser_ev,
   // pins from outside
   input wire logic [pis_pkg::NUM_DAC-1:0] dac_pin,
   input wire logic [pis_pkg::NUM_GPIO-1:0] gpio_pin,
   // cpu side
   input wire logic intr_ack,
   output logic irq_req,
   output logic [3:0] irq_vec,
   // pin and serial control
   output logic [pis_pkg::NUM_GPIO-1:0] gpio_cmos_en,
   output logic ser_proceed,
   output logic ser_master,
   output logic ser_xmit,
   output logic ser_ack,
   output logic ser_stop_req
);
   logic [7:0] gie_reg;
   logic [pis_pkg::NUM_EP-1:0] ep_en_reg;
   logic [pis_pkg::NUM_DAC-1:0] dac_en_reg;
   logic [pis_pkg::NUM_DAC-1:0] dac_pol_reg;
   logic [pis_pkg::NUM_GPIO-1:0] gpio_en_reg;
   logic [pis_pkg::NUM_PORT-1:0] gpio_pol_reg;
   logic par_en_reg;
   logic [7:0] sc_reg;
   logic [pis_pkg::NUM_SRC-1:0] pend_reg;
   logic [pis_pkg::NUM_DAC-1:0] dac_s1_reg, dac_s2_reg;
   logic [pis_pkg::NUM_GPIO-1:0] gpio_s1_reg, gpio_s2_reg;
   logic nack_seen_reg, arb_wait_reg;
   pis_pkg::pis_mctx_type mctx_reg;
   logic setup, wr, rd_ok;
   logic [31:0] rd_data;
   logic [pis_pkg::NUM_GPIO-1:0] gpio_pol_bits;
   logic dac_fire, gpio_fire;
   logic [pis_pkg::NUM_SRC-1:0] src_set, src_en, src_clr, req;
   logic [3:0] vec_next;
   logic ser_fire, ser_pause;

   // ------------------------------------------------------------
   // apb access, zero wait states
   // ------------------------------------------------------------
   assign setup = psel & ~penable;
   assign wr = psel & penable & pwrite;

   always_comb begin
      rd_ok = 1'b1;
      rd_data = pis_pkg::RST_WORD;
      unique case (paddr)
         pis_pkg::ADDR_GIE: rd_data = {24'h00_0000, gie_reg};
         pis_pkg::ADDR_EP_EN: rd_data = {27'h000_0000, ep_en_reg};
         pis_pkg::ADDR_VECTOR: rd_data = {27'h000_0000, irq_vec, 1'b0};
         pis_pkg::ADDR_DAC_EN: rd_data = {24'h00_0000, dac_en_reg};
         pis_pkg::ADDR_DAC_POL: rd_data = {24'h00_0000, dac_pol_reg};
         pis_pkg::ADDR_GPIO_EN: rd_data = gpio_en_reg;
         pis_pkg::ADDR_GPIO_POL: rd_data = {28'h000_0000, gpio_pol_reg};
         pis_pkg::ADDR_CONFIG: rd_data = {31'h0000_0000, par_en_reg};
         pis_pkg::ADDR_PENDING: rd_data = {20'h0_0000, pend_reg};
         pis_pkg::ADDR_SERIAL_SC: rd_data = {24'h00_0000, sc_reg};
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= pis_pkg::RST_WORD;
      end else begin
         pready <= setup;
         pslverr <= setup & ~rd_ok;
         prdata <= (setup && !pwrite) ? rd_data : pis_pkg::RST_WORD;
      end
   end

   // acknowledge never touches the enables, only software writes do
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gie_reg <= pis_pkg::RST_BYTE;
         ep_en_reg <= '0;
         dac_en_reg <= '0;
         dac_pol_reg <= '0;
         gpio_en_reg <= '0;
         gpio_pol_reg <= '0;
         par_en_reg <= 1'b0;
      end else if (wr) begin
         if (paddr == pis_pkg::ADDR_GIE) gie_reg <= pwdata[7:0];
         if (paddr == pis_pkg::ADDR_EP_EN) ep_en_reg <= pwdata[pis_pkg::NUM_EP-1:0];
         if (paddr == pis_pkg::ADDR_DAC_EN) dac_en_reg <= pwdata[7:0]; // [R7]
         if (paddr == pis_pkg::ADDR_DAC_POL) dac_pol_reg <= pwdata[7:0];
         if (paddr == pis_pkg::ADDR_GPIO_EN) gpio_en_reg <= pwdata; // [R11]
         if (paddr == pis_pkg::ADDR_GPIO_POL) gpio_pol_reg <= pwdata[3:0];
         if (paddr == pis_pkg::ADDR_CONFIG) par_en_reg <= pwdata[pis_pkg::CFG_PAR_EN];
      end
   end

   // ------------------------------------------------------------
   // pin synchronisers and edge triggers
   // ------------------------------------------------------------
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         dac_s1_reg <= '0;
         dac_s2_reg <= '0;
         gpio_s1_reg <= '0;
         gpio_s2_reg <= '0;
      end else begin
         dac_s1_reg <= dac_pin;
         dac_s2_reg <= dac_s1_reg;
         gpio_s1_reg <= gpio_pin;
         gpio_s2_reg <= gpio_s1_reg;
      end
   end

   always_comb begin
      for (int p = 0; p < pis_pkg::NUM_PORT; p++) begin
         gpio_pol_bits[p*8 +: 8] = {8{gpio_pol_reg[p]}}; // [R8]
      end
   end

   // one shared vector per pin group; firmware reads the ports to tell pins apart
   pis_edge_lock #(.W(pis_pkg::NUM_DAC)) u_dac ( // [R5]
      .pclk(pclk),
      .presetn(presetn),
      .pin(dac_s2_reg),
      .en(dac_en_reg),
      .pol(dac_pol_reg),
      .block(1'b0),
      .fire(dac_fire),
      .locked()
   );

   pis_edge_lock #(.W(pis_pkg::NUM_GPIO)) u_gpio ( // [R9]
      .pclk(pclk),
      .presetn(presetn),
      .pin(gpio_s2_reg),
      .en(gpio_en_reg),
      .pol(gpio_pol_bits),
      .block(par_en_reg), // [R12]
      .fire(gpio_fire),
      .locked()
   );

   // ------------------------------------------------------------
   // serial controller status/control and its interrupt
   // ------------------------------------------------------------
   assign ser_pause = ser_ev.srx_byte | ser_ev.srx_stop & ~nack_seen_reg
                    | ser_ev.stx_byte | ser_ev.mtx_byte;
   assign ser_fire = sc_reg[pis_pkg::SC_ENABLE]
                   & (ser_ev.srx_byte // [R15]
                      | ser_ev.srx_stop & ~nack_seen_reg // [R16]
                      | ser_ev.stx_byte // [R17]
                      | ser_ev.mtx_byte // [R18]
                      | ser_ev.mrx_byte // [R19]
                      | ser_ev.bus_stop & arb_wait_reg); // [R20]

   // hardware updates follow the software write so that they win
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sc_reg <= pis_pkg::RST_BYTE;
      end else begin
         if (wr && paddr == pis_pkg::ADDR_SERIAL_SC) sc_reg <= pwdata[7:0];
         if (ser_pause) sc_reg[pis_pkg::SC_PROCEED] <= 1'b0; // [R21]
         if (ser_ev.srx_byte) sc_reg[pis_pkg::SC_ADDR] <= ser_ev.first_byte; // [R15]
         if (ser_ev.srx_stop && !nack_seen_reg) sc_reg[pis_pkg::SC_STOP] <= 1'b1; // [R16]
         if (ser_ev.stx_byte) sc_reg[pis_pkg::SC_ACK] <= ser_ev.master_ack; // [R17]
         if (ser_ev.arb_lost) begin
            sc_reg[pis_pkg::SC_MASTER] <= 1'b0; // [R20]
            sc_reg[pis_pkg::SC_ARBL] <= 1'b1;
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         nack_seen_reg <= 1'b0;
         arb_wait_reg <= 1'b0;
      end else begin
         if (ser_ev.srx_byte) nack_seen_reg <= ~sc_reg[pis_pkg::SC_ACK];
         else if (ser_ev.srx_stop) nack_seen_reg <= 1'b0;
         if (ser_ev.arb_lost) arb_wait_reg <= 1'b1;
         else if (ser_ev.bus_stop) arb_wait_reg <= 1'b0;
      end
   end

   // master context remembers which byte interrupt the next write answers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mctx_reg <= pis_pkg::CTX_NONE;
         ser_stop_req <= 1'b0;
      end else begin
         ser_stop_req <= 1'b0;
         if (ser_ev.mtx_byte) begin
            mctx_reg <= pis_pkg::CTX_MTX;
         end else if (ser_ev.mrx_byte) begin
            mctx_reg <= pis_pkg::CTX_MRX;
         end else if (ser_ev.arb_lost) begin
            mctx_reg <= pis_pkg::CTX_NONE;
         end else if (wr && paddr == pis_pkg::ADDR_SERIAL_SC) begin
            unique case (mctx_reg)
               pis_pkg::CTX_MTX:
                  ser_stop_req <= ~pwdata[pis_pkg::SC_MASTER]; // [R18]
               pis_pkg::CTX_MRX:
                  ser_stop_req <= ~pwdata[pis_pkg::SC_MASTER]
                                & pwdata[pis_pkg::SC_PROCEED]; // [R19]
               pis_pkg::CTX_NONE: ser_stop_req <= 1'b0;
               default: ser_stop_req <= 1'b0;
            endcase
            mctx_reg <= pis_pkg::CTX_NONE;
         end
      end
   end

   // ------------------------------------------------------------
   // pending flags, enables and priority
   // ------------------------------------------------------------
   always_comb begin
      src_set = '0;
      src_set[pis_pkg::SRC_BUS_RESET] = bus_reset_ev;
      src_set[pis_pkg::SRC_T128] = t128_ev;
      src_set[pis_pkg::SRC_T1024] = t1024_ev;
      for (int e = 0; e < pis_pkg::NUM_EP; e++) begin
         // in: host ack; out: device ack; no ack means no event
         src_set[pis_pkg::SRC_EP0 + e] = ep_ev.done[e] & ep_ev.acked[e]; // [R1] [R2] [R3]
      end
      src_set[pis_pkg::SRC_DAC] = dac_fire;
      src_set[pis_pkg::SRC_GPIO] = par_en_reg ? par_ev : gpio_fire; // [R12]
      src_set[pis_pkg::SRC_SERIAL] = ser_fire;
      src_en = '0;
      src_en[pis_pkg::SRC_BUS_RESET] = gie_reg[pis_pkg::GIE_BUS_RESET];
      src_en[pis_pkg::SRC_T128] = gie_reg[pis_pkg::GIE_T128];
      src_en[pis_pkg::SRC_T1024] = gie_reg[pis_pkg::GIE_T1024];
      src_en[pis_pkg::SRC_EP0 +: pis_pkg::NUM_EP] = ep_en_reg;
      src_en[pis_pkg::SRC_DAC] = gie_reg[pis_pkg::GIE_DAC];
      src_en[pis_pkg::SRC_GPIO] = gie_reg[pis_pkg::GIE_GPIO]; // [R13]
      src_en[pis_pkg::SRC_SERIAL] = gie_reg[pis_pkg::GIE_SERIAL];
      src_clr = '0;
      if (intr_ack && irq_req) src_clr[irq_vec - 4'h1] = 1'b1;
   end

   assign req = pend_reg & src_en; // [R23]

   always_comb begin
      vec_next = 4'h0;
      for (int k = pis_pkg::NUM_SRC - 1; k >= 0; k--) begin
         if (req[k]) vec_next = 4'(k + 1); // [R24]
      end
   end

   // a new event in the acknowledge cycle survives the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pend_reg <= '0;
      end else begin
         pend_reg <= (pend_reg & ~src_clr) | src_set; // [R23]
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_req <= 1'b0;
         irq_vec <= 4'h0;
         gpio_cmos_en <= '0;
         ser_proceed <= 1'b0;
         ser_master <= 1'b0;
         ser_xmit <= 1'b0;
         ser_ack <= 1'b0;
      end else begin
         irq_req <= |req;
         irq_vec <= vec_next;
         gpio_cmos_en <= gpio_en_reg; // [R14]
         ser_proceed <= sc_reg[pis_pkg::SC_PROCEED];
         ser_master <= sc_reg[pis_pkg::SC_MASTER];
         ser_xmit <= sc_reg[pis_pkg::SC_XMIT];
         ser_ack <= sc_reg[pis_pkg::SC_ACK];
      end
   end

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   property p_ep_raise;
      ep_ev.done[0] && ep_ev.acked[0] |=> pend_reg[pis_pkg::SRC_EP0];
   endproperty
   a_ep_raise: assert property (p_ep_raise) else $error("endpoint ack not latched"); // [R2]

   property p_ep_cause;
      $rose(pend_reg[pis_pkg::SRC_EP0]) |-> $past(ep_ev.done[0] && ep_ev.acked[0]);
   endproperty
   a_ep_cause: assert property (p_ep_cause) else $error("endpoint pend without ack"); // [R3]

   property p_dac_keep;
      intr_ack && !(wr && paddr == pis_pkg::ADDR_DAC_EN) |=> $stable(dac_en_reg);
   endproperty
   a_dac_keep: assert property (p_dac_keep) else $error("dac enables changed on ack"); // [R7]

   property p_par_block;
      par_en_reg && !par_ev |=> !$rose(pend_reg[pis_pkg::SRC_GPIO]);
   endproperty
   a_par_block: assert property (p_par_block) else $error("gpio pend while parallel on"); // [R12]

   property p_par_irq;
      par_en_reg && par_ev && gie_reg[pis_pkg::GIE_GPIO] && !intr_ack
      |=> pend_reg[pis_pkg::SRC_GPIO] ##1 irq_req;
   endproperty
   a_par_irq: assert property (p_par_irq) else $error("parallel irq not raised"); // [R13]

   property p_proceed_clr;
      ser_ev.srx_byte |=> !sc_reg[pis_pkg::SC_PROCEED] ##1 !ser_proceed;
   endproperty
   a_proceed_clr: assert property (p_proceed_clr) else $error("proceed not cleared"); // [R21]

   property p_stop_mask;
      ser_ev.srx_stop && nack_seen_reg |-> !ser_fire;
   endproperty
   a_stop_mask: assert property (p_stop_mask) else $error("stop after nack interrupted"); // [R16]

   sequence s_arb_lost;
      ser_ev.arb_lost ##1 !sc_reg[pis_pkg::SC_MASTER] && sc_reg[pis_pkg::SC_ARBL];
   endsequence
   property p_arb;
      ser_ev.arb_lost |-> s_arb_lost;
   endproperty
   a_arb: assert property (p_arb) else $error("arbitration loss not recorded"); // [R20]

   sequence s_mtx_release;
      ser_ev.mtx_byte ##1 (wr && paddr == pis_pkg::ADDR_SERIAL_SC
                           && !pwdata[pis_pkg::SC_MASTER] && !ser_ev.mrx_byte
                           && !ser_ev.arb_lost && mctx_reg == pis_pkg::CTX_MTX);
   endsequence
   property p_mtx_stop;
      s_mtx_release |=> ser_stop_req;
   endproperty
   a_mtx_stop: assert property (p_mtx_stop) else $error("stop not issued"); // [R18]

   property p_prio;
      req[pis_pkg::SRC_BUS_RESET] |=> irq_vec == 4'h1;
   endproperty
   a_prio: assert property (p_prio) else $error("bus reset not top priority"); // [R24]

endmodule : pis_irq_ctrl

// ==== testbench/pis_far_side.sv ====
`timescale 1ns/1ps
// ------------------------------------------------------------
// far side: host handshakes, pin levels, serial engine
// ------------------------------------------------------------
module pis_far_side (
   // clock
   input wire logic pclk,
   // toward the block
   output pis_pkg::pis_ep_ev_type ep_ev,
   output pis_pkg::pis_ser_ev_type ser_ev,
   output logic [7:0] dac_pin,
   output logic [31:0] gpio_pin
);
   initial begin
      ep_ev = '0;
      ser_ev = '0;
      dac_pin = 8'h00;
      gpio_pin = 32'h0000_0000;
   end
   // end of transaction; ack marks the final handshake seen
   task xfer(input logic [4:0] m, input logic [4:0] in, input logic [4:0] ack);
      @(posedge pclk);
      ep_ev <= {m, in, ack & m};
      @(posedge pclk);
      ep_ev <= '0;
   endtask : xfer
   task ser(input logic [8:0] v);
      @(posedge pclk);
      ser_ev <= v;
      @(posedge pclk);
      ser_ev <= '0;
   endtask : ser
   // pins are levels and hold until changed
   task pins(input logic [7:0] d, input logic [31:0] g);
      @(posedge pclk);
      dac_pin <= d;
      gpio_pin <= g;
   endtask : pins
endmodule : pis_far_side

// ==== testbench/peripheral_interrupt_sources_test.sv ====
`timescale 1ns/1ps
`define CHK(a, x) begin check_count++; if ((a) !== (x)) begin n_mismatch++; \
   $display("mismatch t=%0t got %0h exp %0h", $time, (a), (x)); end end
module peripheral_interrupt_sources_test;
   logic pclk = 1'b0, presetn, psel, penable, pwrite;
   logic intr_ack, par_ev, pready, pslverr, irq_req, e, seen;
   logic ser_proceed, ser_master, ser_xmit, ser_ack, ser_stop_req;
   logic [2:0] tmr;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, q, gpio_cmos_en, gpio_pin;
   logic [3:0] irq_vec;
   logic [7:0] dac_pin;
   pis_pkg::pis_ep_ev_type ep_ev;
   pis_pkg::pis_ser_ev_type ser_ev;
   int n_mismatch = 0, check_count = 0, cyc = 0;
   always #2.5 pclk = ~pclk;
   pis_far_side i_pis_far_side (.pclk(pclk), .ep_ev(ep_ev), .ser_ev(ser_ev),
      .dac_pin(dac_pin), .gpio_pin(gpio_pin));
   pis_irq_ctrl i_pis_irq_ctrl (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .bus_reset_ev(tmr[0]), .t128_ev(tmr[1]),
      .t1024_ev(tmr[2]), .ep_ev(ep_ev), .par_ev(par_ev), .ser_ev(ser_ev), .dac_pin(dac_pin),
      .gpio_pin(gpio_pin), .intr_ack(intr_ack), .irq_req(irq_req), .irq_vec(irq_vec),
      .gpio_cmos_en(gpio_cmos_en), .ser_proceed(ser_proceed), .ser_master(ser_master),
      .ser_xmit(ser_xmit), .ser_ack(ser_ack), .ser_stop_req(ser_stop_req));
   // ------------------------------------------------------------
   // bus and helper tasks
   // ------------------------------------------------------------
   task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin @(posedge pclk); end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask : wr
   task rd(input logic [11:0] a, input logic [31:0] x, input logic [31:0] m = 32'hffff_ffff);
      apb(1'b0, a, 32'h0000_0000);
      `CHK(q & m, x)
   endtask : rd
   task wt(input int n);
      repeat (n) @(posedge pclk);
   endtask : wt
   // one acknowledge per pass; spacing lets irq_vec settle first
   task drain(input int n = 6);
      repeat (n) begin
         @(posedge pclk) intr_ack <= 1'b1;
         @(posedge pclk) intr_ack <= 1'b0;
         wt(3);
      end
   endtask : drain
   task end_sim;
      if (n_mismatch == 0 && check_count > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : end_sim
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         end_sim();
      end
   end
   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   initial begin
      {presetn, psel, penable, pwrite, intr_ack, par_ev, tmr, paddr, pwdata} = '0;
      wt(10);
      presetn <= 1'b1;
      rd(pis_pkg::ADDR_PENDING, 32'h0);
      apb(1'b0, 12'h004, 32'h0);
      `CHK({e, q}, {1'b1, 32'h0})
      wr(pis_pkg::ADDR_GIE, 32'h77);
      wr(pis_pkg::ADDR_EP_EN, 32'h1f);
      i_pis_far_side.xfer(5'h02, 5'h02, 5'h00);
      wt(4);
      rd(pis_pkg::ADDR_PENDING, 32'h0);
      i_pis_far_side.xfer(5'h02, 5'h02, 5'h02);
      wt(4);
      rd(pis_pkg::ADDR_PENDING, 32'h010);
      drain();
      @(posedge pclk) tmr <= 3'b111;
      @(posedge pclk) tmr <= 3'b000;
      i_pis_far_side.xfer(5'h10, 5'h00, 5'h10);
      wt(4);
      `CHK({irq_req, irq_vec}, 5'h11)
      rd(pis_pkg::ADDR_VECTOR, 32'h2);
      drain(1);
      `CHK(irq_vec, 4'h2)
      rd(pis_pkg::ADDR_PENDING, 32'h86);
      drain();
      // dac: pin0 rising, pin1 falling
      wr(pis_pkg::ADDR_DAC_EN, 32'h03);
      wr(pis_pkg::ADDR_DAC_POL, 32'h01);
      i_pis_far_side.pins(8'h02, 32'h0);
      wt(6);
      rd(pis_pkg::ADDR_PENDING, 32'h0);
      i_pis_far_side.pins(8'h03, 32'h0);
      wt(6);
      rd(pis_pkg::ADDR_PENDING, 32'h200);
      drain();
      i_pis_far_side.pins(8'h01, 32'h0);
      wt(6);
      rd(pis_pkg::ADDR_PENDING, 32'h0);
      rd(pis_pkg::ADDR_DAC_EN, 32'h03);
      i_pis_far_side.pins(8'h00, 32'h0);
      i_pis_far_side.pins(8'h02, 32'h0);
      wt(4);
      i_pis_far_side.pins(8'h00, 32'h0);
      wt(6);
      rd(pis_pkg::ADDR_PENDING, 32'h200);
      drain();
      // gpio: port0 active high
      wr(pis_pkg::ADDR_GPIO_POL, 32'h1);
      wr(pis_pkg::ADDR_GPIO_EN, 32'h3);
      i_pis_far_side.pins(8'h00, 32'h1);
      wt(6);
      rd(pis_pkg::ADDR_PENDING, 32'h400);
      `CHK(gpio_cmos_en, 32'h3)
      drain();
      i_pis_far_side.pins(8'h00, 32'h3);
      wt(6);
      rd(pis_pkg::ADDR_PENDING, 32'h0);
      rd(pis_pkg::ADDR_GPIO_EN, 32'h3);
      i_pis_far_side.pins(8'h00, 32'h0);
      wr(pis_pkg::ADDR_CONFIG, 32'h1);
      i_pis_far_side.pins(8'h00, 32'h2);
      wt(6);
      rd(pis_pkg::ADDR_PENDING, 32'h0);
      wr(pis_pkg::ADDR_GPIO_EN, 32'h0);
      @(posedge pclk) par_ev <= 1'b1;
      @(posedge pclk) par_ev <= 1'b0;
      wt(3);
      `CHK({irq_req, irq_vec}, 5'h1b)
      wr(pis_pkg::ADDR_GIE, 32'h57);
      wt(2);
      `CHK(irq_req, 1'b0)
      wr(pis_pkg::ADDR_GIE, 32'h77);
      drain();
      // serial: master transmit, then master receive, each followed by stop
      for (int k = 0; k < 2; k++) begin
         wr(pis_pkg::ADDR_SERIAL_SC, 32'h83);
         i_pis_far_side.ser(k ? 9'h004 : 9'h008);
         wt(3);
         rd(pis_pkg::ADDR_SERIAL_SC, k ? 32'h83 : 32'h82, 32'h83);
         `CHK({ser_master, ser_proceed}, {1'b1, k[0]})
         wr(pis_pkg::ADDR_SERIAL_SC, 32'h81);
         seen = 1'b0;
         repeat (4) @(posedge pclk) seen |= ser_stop_req;
         `CHK(seen, 1'b1)
      end
      drain();
      i_pis_far_side.ser(9'h180);
      wt(3);
      rd(pis_pkg::ADDR_SERIAL_SC, 32'h10, 32'h11);
      drain();
      i_pis_far_side.ser(9'h040);
      wt(3);
      rd(pis_pkg::ADDR_PENDING, 32'h0);
      wr(pis_pkg::ADDR_SERIAL_SC, 32'h89);
      i_pis_far_side.ser(9'h100);
      drain();
      i_pis_far_side.ser(9'h040);
      wt(3);
      rd(pis_pkg::ADDR_SERIAL_SC, 32'h20, 32'h20);
      drain();
      wr(pis_pkg::ADDR_SERIAL_SC, 32'h81);
      i_pis_far_side.ser(9'h030);
      wt(3);
      rd(pis_pkg::ADDR_SERIAL_SC, 32'h08, 32'h09);
      drain();
      wr(pis_pkg::ADDR_SERIAL_SC, 32'h83);
      i_pis_far_side.ser(9'h002);
      wt(3);
      rd(pis_pkg::ADDR_SERIAL_SC, 32'h40, 32'h42);
      rd(pis_pkg::ADDR_PENDING, 32'h0);
      i_pis_far_side.ser(9'h001);
      wt(3);
      rd(pis_pkg::ADDR_PENDING, 32'h800);
      end_sim();
   end
endmodule : peripheral_interrupt_sources_test
